// ### common/adcc_map.vh
// Register map, field positions and codes of the async DMA context control block.
// Assumes byte addresses on a 12-bit register port, 32-bit data words.
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// Context register offsets
`define ADCC_CTX0_SET      12'h180
`define ADCC_CTX0_CLR      12'h184
`define ADCC_CTX0_PTR      12'h19c
`define ADCC_CTX1_SET      12'h1a0
`define ADCC_CTX1_CLR      12'h1a4
`define ADCC_CTX1_PTR      12'h1ac
`define ADCC_CTX2_SET      12'h1c0
`define ADCC_CTX2_CLR      12'h1c4
`define ADCC_CTX2_PTR      12'h1cc
`define ADCC_CTX3_SET      12'h1e0
`define ADCC_CTX3_CLR      12'h1e4
`define ADCC_CTX3_PTR      12'h1ec

// Interrupt registers
`define ADCC_IRQ_STATUS    12'h1f0
`define ADCC_IRQ_MASK      12'h1f4

// Control register fields
`define ADCC_RUN_BIT       15
`define ADCC_WAKE_BIT      12
`define ADCC_DEAD_BIT      11
`define ADCC_ACTIVE_BIT    10
`define ADCC_SPD_MSB       7
`define ADCC_SPD_LSB       5
`define ADCC_CODE_MSB      4
`define ADCC_CODE_LSB      0

// Command pointer fields
`define ADCC_PTR_ADDR_MSB  31
`define ADCC_PTR_ADDR_LSB  4
`define ADCC_PTR_CNT_MSB   3
`define ADCC_PTR_CNT_LSB   0

// Speed codes
`define ADCC_SPD_S100      3'h0
`define ADCC_SPD_S200      3'h1
`define ADCC_SPD_S400      3'h2

// Reset values and internal error code
`define ADCC_SPD_RST       3'h0
`define ADCC_CODE_RST      5'h00
`define ADCC_EVT_FETCH_ERR 5'h10

`endif

// ### hw/adcc_irq.v
// Sticky interrupt status with mask and one level output.
// Assumes one-cycle event pulses and one-cycle register strobes on the same clock.
`timescale 1ns/1ps
module adcc_irq (
    input  wire       clk_in,
    input  wire       rst_b_in,
    input  wire [7:0] event_in,
    input  wire       status_rd_in,
    input  wire       mask_wr_in,
    input  wire [7:0] mask_data_in,
    output wire [7:0] status_out,
    output wire [7:0] mask_out,
    output wire       irq_out
);
    reg [7:0] status_reg;
    reg [7:0] mask_reg;

    // Read clears, but a new event in that cycle is kept
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_reg <= 8'h00;
            mask_reg   <= 8'h00;
        end else begin
            status_reg <= (status_rd_in ? 8'h00 : status_reg) | event_in;
            if (mask_wr_in) begin
                mask_reg <= mask_data_in;
            end
        end
    end

    assign status_out = status_reg;
    assign mask_out   = mask_reg;
    assign irq_out    = |(status_reg & mask_reg);
endmodule

// ### hw/adcc_ctx.v
// One asynchronous DMA context: control bits and descriptor sequencing.
// Assumes the top arbitrates fetches and routes link completions to it.
`include "adcc_map.vh"
`timescale 1ns/1ps
module adcc_ctx #(
    parameter IS_RX = 0
) (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        soft_rst_in,
    input  wire        set_wr_in,
    input  wire        clr_wr_in,
    input  wire [31:0] wdata_in,
    input  wire        cnt_valid_in,
    input  wire        grant_in,
    input  wire        fetch_done_in,
    input  wire        fetch_fatal_in,
    input  wire        next_valid_in,
    input  wire        link_done_in,
    input  wire [4:0]  link_ack_in,
    input  wire        link_fail_in,
    input  wire [4:0]  link_err_in,
    input  wire [2:0]  link_speed_in,
    output wire [31:0] ctrl_out,
    output wire        fetch_req_out,
    output wire        advance_out,
    output wire        done_evt_out,
    output wire        dead_evt_out
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_FETCH = 3'd1;
    localparam [2:0] ST_FWAIT = 3'd2;
    localparam [2:0] ST_XFER  = 3'd3;
    localparam [2:0] ST_SUSP  = 3'd4;
    localparam [2:0] ST_DEAD  = 3'd5;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg       run_reg;
    reg       wake_reg;
    reg       dead_reg;
    reg [2:0] spd_reg;
    reg [4:0] code_reg;

    wire run_clr  = clr_wr_in && wdata_in[`ADCC_RUN_BIT];
    wire run_set  = set_wr_in && wdata_in[`ADCC_RUN_BIT];
    wire wake_set = set_wr_in && wdata_in[`ADCC_WAKE_BIT];
    wire fatal    = (state_reg == ST_FWAIT) && fetch_done_in && fetch_fatal_in;
    wire xfer_end = (state_reg == ST_XFER) && link_done_in;

    // Descriptor sequencing
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (run_reg && !dead_reg && cnt_valid_in) state_next = ST_FETCH;
            ST_FETCH: if (grant_in) state_next = ST_FWAIT;
            ST_FWAIT: if (fetch_done_in) state_next = fetch_fatal_in ? ST_DEAD : ST_XFER;
            ST_XFER:  if (link_done_in) state_next = next_valid_in ? ST_FETCH : ST_SUSP;
            ST_SUSP:  if (wake_reg) state_next = ST_FETCH;
            ST_DEAD:  state_next = ST_DEAD;
            default:  state_next = ST_IDLE;
        endcase
        if (!run_reg) begin
            state_next = ST_IDLE;
        end
    end

    // Control bits and state
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= ST_IDLE;
            run_reg   <= 1'b0;
            wake_reg  <= 1'b0;
            dead_reg  <= 1'b0;
            spd_reg   <= `ADCC_SPD_RST;
            code_reg  <= `ADCC_CODE_RST;
        end else if (soft_rst_in) begin
            state_reg <= ST_IDLE;
            run_reg   <= 1'b0;
            wake_reg  <= 1'b0;
            dead_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (run_set) begin
                run_reg <= 1'b1;
            end else if (run_clr) begin
                run_reg <= 1'b0;
            end
            if (wake_set) begin
                wake_reg <= 1'b1;
            end else if (grant_in && state_reg == ST_FETCH) begin
                wake_reg <= 1'b0;
            end
            if (fatal) begin
                dead_reg <= 1'b1;
            end else if (run_clr && run_reg) begin
                dead_reg <= 1'b0;
            end
            if (xfer_end) begin
                code_reg <= link_fail_in ? link_err_in : link_ack_in;
            end else if (fatal) begin
                code_reg <= `ADCC_EVT_FETCH_ERR;
            end
            if (xfer_end && IS_RX != 0) begin
                spd_reg <= link_speed_in;
            end
        end
    end

    wire active = (state_reg == ST_FETCH) || (state_reg == ST_FWAIT) ||
                  (state_reg == ST_XFER);

    assign ctrl_out = {16'h0000, run_reg, 2'b00, wake_reg, dead_reg, active, 2'b00,
                       spd_reg, code_reg};
    assign fetch_req_out = (state_reg == ST_FETCH) && run_reg;
    assign advance_out   = xfer_end && next_valid_in && run_reg;
    assign done_evt_out  = xfer_end;
    assign dead_evt_out  = fatal;
endmodule

// ### hw/adcc_top.v
// Top of the async DMA context control block: register port, command
// pointers, fetch arbitration, link completion routing and interrupts.
// Assumes a fetch engine and link core on the same clock; all inputs are
// synchronous, so none is resynchronised.
//
// Added by the designer: the strobed register port.
`include "adcc_map.vh"
`timescale 1ns/1ps
//
// How it works
// - Hardware changes run only on hardware or software reset.
// - Software sets wake to resume; every descriptor fetch clears wake.
// - Fatal error sets dead; clearing run clears dead. The code clears dead only if run is still set when the clear is written.
// - Active reads one while the context processes descriptors.
// - Receive contexts report speed 0=100, 1=200, 2=400 Mbit/s.
// - Event field holds link acknowledge, or link error code on link failure; a fatal fetch writes the internal error.
// - Reserved control bits read back zero regardless of writes.
// - Set address sets written run and wake ones, clear address clears run only; both read value.
// - Setting run starts by fetching the block the command pointer names.
// - Pointer bits 31..4 address a 16-byte aligned descriptor block.
// - Low four bits count descriptors; zero marks the address invalid.
module adcc_top (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        soft_reset_in,
    input  wire [11:0] addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rdata_out,
    output reg         fetch_req_out,
    output reg  [1:0]  fetch_ctx_out,
    output reg  [31:0] fetch_addr_out,
    output reg  [3:0]  fetch_count_out,
    input  wire        fetch_done_in,
    input  wire        fetch_fatal_in,
    input  wire [31:0] fetch_next_ptr_in,
    output reg         xfer_go_out,
    output reg  [1:0]  xfer_ctx_out,
    input  wire        link_done_in,
    input  wire [1:0]  link_ctx_in,
    input  wire [4:0]  link_ack_in,
    input  wire        link_fail_in,
    input  wire [4:0]  link_err_in,
    input  wire [2:0]  link_speed_in,
    output wire        irq_out
);
    // Set-address lookup per context
    function [11:0] adcc_set_off;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    adcc_set_off = `ADCC_CTX0_SET;
                2'd1:    adcc_set_off = `ADCC_CTX1_SET;
                2'd2:    adcc_set_off = `ADCC_CTX2_SET;
                default: adcc_set_off = `ADCC_CTX3_SET;
            endcase
        end
    endfunction

    // Clear-address lookup per context
    function [11:0] adcc_clr_off;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    adcc_clr_off = `ADCC_CTX0_CLR;
                2'd1:    adcc_clr_off = `ADCC_CTX1_CLR;
                2'd2:    adcc_clr_off = `ADCC_CTX2_CLR;
                default: adcc_clr_off = `ADCC_CTX3_CLR;
            endcase
        end
    endfunction

    // Pointer-address lookup; pointer offsets are not evenly spaced
    function [11:0] adcc_ptr_off;
        input [1:0] idx;
        begin
            case (idx)
                2'd0:    adcc_ptr_off = `ADCC_CTX0_PTR;
                2'd1:    adcc_ptr_off = `ADCC_CTX1_PTR;
                2'd2:    adcc_ptr_off = `ADCC_CTX2_PTR;
                default: adcc_ptr_off = `ADCC_CTX3_PTR;
            endcase
        end
    endfunction

    // Round-robin pick of the next requester after the last winner
    function [2:0] adcc_pick;
        input [3:0] req;
        input [1:0] last;
        reg   [1:0] cand;
        integer     k;
        begin
            adcc_pick = 3'b000;
            cand      = 2'd0;
            for (k = 4; k >= 1; k = k - 1) begin
                cand = last + k[1:0];
                if (req[cand]) begin
                    adcc_pick = {1'b1, cand};
                end
            end
        end
    endfunction

    reg  [31:0] ptr_reg      [0:3];
    reg  [31:0] next_ptr_reg [0:3];
    reg  [3:0]  next_ok_reg;
    reg         busy_reg;
    reg  [1:0]  owner_reg;
    reg  [1:0]  last_reg;

    wire [3:0]  set_hit;
    wire [3:0]  clr_hit;
    wire [3:0]  ptr_hit_wr;
    wire [3:0]  fetch_req;
    wire [3:0]  advance;
    wire [3:0]  done_evt;
    wire [3:0]  dead_evt;
    wire [3:0]  grant;
    wire [3:0]  fdone;
    wire [3:0]  ldone;
    wire [3:0]  cnt_valid;
    wire [31:0] ctrl [0:3];
    wire [7:0]  irq_status;
    wire [7:0]  irq_mask;
    wire [2:0]  pick = adcc_pick(fetch_req, last_reg);
    wire        do_grant = !busy_reg && pick[2];

    wire status_rd = rd_in && (addr_in == `ADCC_IRQ_STATUS);
    wire mask_wr   = wr_in && (addr_in == `ADCC_IRQ_MASK);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_ctx
            assign set_hit[g]    = wr_in && (addr_in == adcc_set_off(g));
            assign clr_hit[g]    = wr_in && (addr_in == adcc_clr_off(g));
            assign ptr_hit_wr[g] = wr_in && (addr_in == adcc_ptr_off(g));
            assign cnt_valid[g]  = |ptr_reg[g][`ADCC_PTR_CNT_MSB:`ADCC_PTR_CNT_LSB];
            assign grant[g]      = do_grant && (pick[1:0] == g);
            assign fdone[g]      = fetch_done_in && busy_reg && (owner_reg == g);
            assign ldone[g]      = link_done_in && (link_ctx_in == g);

            // Contexts 0 and 1 transmit, 2 and 3 receive
            adcc_ctx #(
                .IS_RX (g >= 2)
            ) u_ctx (
                .clk_in         (clk_in),
                .rst_b_in       (rst_b_in),
                .soft_rst_in    (soft_reset_in),
                .set_wr_in      (set_hit[g]),
                .clr_wr_in      (clr_hit[g]),
                .wdata_in       (wdata_in),
                .cnt_valid_in   (cnt_valid[g]),
                .grant_in       (grant[g]),
                .fetch_done_in  (fdone[g]),
                .fetch_fatal_in (fetch_fatal_in),
                .next_valid_in  (next_ok_reg[g]),
                .link_done_in   (ldone[g]),
                .link_ack_in    (link_ack_in),
                .link_fail_in   (link_fail_in),
                .link_err_in    (link_err_in),
                .link_speed_in  (link_speed_in),
                .ctrl_out       (ctrl[g]),
                .fetch_req_out  (fetch_req[g]),
                .advance_out    (advance[g]),
                .done_evt_out   (done_evt[g]),
                .dead_evt_out   (dead_evt[g])
            );
        end
    endgenerate

    // Command pointers and the branch pointer each fetch returns
    integer i;
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 4; i = i + 1) begin
                ptr_reg[i]      <= 32'h0000_0000;
                next_ptr_reg[i] <= 32'h0000_0000;
            end
            next_ok_reg <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (advance[i]) begin
                    ptr_reg[i] <= next_ptr_reg[i];
                end else if (ptr_hit_wr[i]) begin
                    ptr_reg[i] <= wdata_in;
                end
                if (fdone[i]) begin
                    next_ptr_reg[i] <= fetch_next_ptr_in;
                    next_ok_reg[i]  <= |fetch_next_ptr_in[`ADCC_PTR_CNT_MSB:`ADCC_PTR_CNT_LSB];
                end
            end
        end
    end

    // One fetch outstanding at a time, shared round robin
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_reg        <= 1'b0;
            owner_reg       <= 2'd0;
            last_reg        <= 2'd3;
            fetch_req_out   <= 1'b0;
            fetch_ctx_out   <= 2'd0;
            fetch_addr_out  <= 32'h0000_0000;
            fetch_count_out <= 4'h0;
        end else begin
            fetch_req_out <= 1'b0;
            if (do_grant) begin
                busy_reg        <= 1'b1;
                owner_reg       <= pick[1:0];
                last_reg        <= pick[1:0];
                fetch_req_out   <= 1'b1;
                fetch_ctx_out   <= pick[1:0];
                fetch_addr_out  <= {ptr_reg[pick[1:0]][`ADCC_PTR_ADDR_MSB:`ADCC_PTR_ADDR_LSB],
                                    4'h0};
                fetch_count_out <= ptr_reg[pick[1:0]][`ADCC_PTR_CNT_MSB:`ADCC_PTR_CNT_LSB];
            end else if (fetch_done_in) begin
                // Release even if the owner was stopped meanwhile
                busy_reg <= 1'b0;
            end
        end
    end

    // Hand a fetched block to the link core
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            xfer_go_out  <= 1'b0;
            xfer_ctx_out <= 2'd0;
        end else begin
            xfer_go_out <= fetch_done_in && busy_reg && !fetch_fatal_in &&
                           ctrl[owner_reg][`ADCC_RUN_BIT];
            if (fetch_done_in && busy_reg) begin
                xfer_ctx_out <= owner_reg;
            end
        end
    end

    // Register read, data in the following cycle only
    // Unmapped addresses fall through to zero, so software probing
    // a hole sees no stale value from an earlier access.
    // Later matches override earlier ones; the offsets never overlap.
    reg [31:0] rd_value;
    integer    j;
    always @* begin
        rd_value = 32'h0000_0000;
        for (j = 0; j < 4; j = j + 1) begin
            if (addr_in == adcc_set_off(j[1:0]) || addr_in == adcc_clr_off(j[1:0])) begin
                rd_value = ctrl[j];
            end
            if (addr_in == adcc_ptr_off(j[1:0])) begin
                rd_value = ptr_reg[j];
            end
        end
        if (addr_in == `ADCC_IRQ_STATUS) begin
            rd_value = {24'h000000, irq_status};
        end
        if (addr_in == `ADCC_IRQ_MASK) begin
            rd_value = {24'h000000, irq_mask};
        end
    end

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= rd_in ? rd_value : 32'h0000_0000;
        end
    end

    // Events: low nibble block done, high nibble context dead
    adcc_irq u_irq (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .event_in     ({dead_evt, done_evt}),
        .status_rd_in (status_rd),
        .mask_wr_in   (mask_wr),
        .mask_data_in (wdata_in[7:0]),
        .status_out   (irq_status),
        .mask_out     (irq_mask),
        .irq_out      (irq_out)
    );
endmodule

// ### verif/adcc_props.sv
// Port-level checker for the async DMA context control top.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module adcc_props (
    input wire        clk_in,
    input wire        rst_b_in,
    input wire [11:0] addr_in,
    input wire        rd_in,
    input wire [31:0] rdata_out,
    input wire        fetch_req_out,
    input wire [1:0]  fetch_ctx_out,
    input wire [31:0] fetch_addr_out,
    input wire [3:0]  fetch_count_out,
    input wire        fetch_done_in,
    input wire        fetch_fatal_in,
    input wire        xfer_go_out,
    input wire [1:0]  xfer_ctx_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Set and clear offsets of the four control words
    wire ctl_a = addr_in[11:7] == 5'h03 && addr_in[4:3] == 2'h0 && addr_in[1:0] == 2'h0;

    chk_req_pulse: assert property (fetch_req_out |=> !fetch_req_out)
        else $error("fetch request longer than one cycle");
    chk_addr_align: assert property (fetch_req_out |-> fetch_addr_out[3:0] == 4'h0)
        else $error("fetch address not block aligned");
    chk_count_valid: assert property (fetch_req_out |-> fetch_count_out != 4'h0)
        else $error("fetch issued with zero count");
    chk_fetch_held: assert property (!fetch_req_out |-> $stable({fetch_addr_out,
        fetch_count_out, fetch_ctx_out}))
        else $error("fetch qualifiers moved between fetches");
    chk_go_cause: assert property (xfer_go_out |-> $past(fetch_done_in) && !$past(fetch_fatal_in)
        && xfer_ctx_out == fetch_ctx_out)
        else $error("transfer start without good fetch");
    chk_fatal_no_go: assert property (fetch_done_in && fetch_fatal_in |=> !xfer_go_out [*2])
        else $error("transfer started after fatal fetch");
    chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    chk_rsvd_zero: assert property ($past(rd_in && ctl_a) |-> rdata_out[31:16] == 16'h0
        && rdata_out[14:13] == 2'h0 && rdata_out[9:8] == 2'h0)
        else $error("reserved control bits not zero");
    chk_unmapped: assert property ($past(rd_in) && $past(addr_in) == 12'h000
        |-> rdata_out == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind adcc_top adcc_props u_props (.clk_in, .rst_b_in, .addr_in, .rd_in, .rdata_out,
    .fetch_req_out, .fetch_ctx_out, .fetch_addr_out, .fetch_count_out, .fetch_done_in,
    .fetch_fatal_in, .xfer_go_out, .xfer_ctx_out);

// ### verif/adcc_far_model.sv
// Far side model: descriptor fetch engine and link core.
// Assumes one clock; reply content and delay are set by the bench.
`timescale 1ns/1ps
module adcc_far_model (
    input  wire        clk_in,
    input  wire        fetch_req_in,
    input  wire        xfer_go_in,
    input  wire [1:0]  xfer_ctx_in,
    input  wire [7:0]  dly_in,
    input  wire        fatal_in,
    input  wire [31:0] nptr_in,
    input  wire [4:0]  ack_in,
    input  wire        fail_in,
    input  wire [2:0]  spd_in,
    output reg         fdone_out,
    output reg         ffatal_out,
    output reg  [31:0] fnext_out,
    output reg         ldone_out,
    output reg  [1:0]  lctx_out,
    output reg  [4:0]  lack_out,
    output reg         lfail_out,
    output reg  [4:0]  lerr_out,
    output reg  [2:0]  lspd_out
);
    // Fetch engine; qualifiers inverted outside the pulse so stale use shows
    initial begin
        fdone_out = 1'b0;
        ffatal_out = 1'b1;
        fnext_out = 32'hffff_ffff;
        forever begin
            @(posedge clk_in);
            if (fetch_req_in === 1'b1) begin
                repeat (dly_in) @(posedge clk_in);
                fdone_out <= 1'b1;
                ffatal_out <= fatal_in;
                fnext_out <= nptr_in;
                @(posedge clk_in);
                fdone_out <= 1'b0;
                ffatal_out <= ~fatal_in;
                fnext_out <= ~nptr_in;
            end
        end
    end

    // Link core; error code is the inverse of the ack, so the two differ
    initial begin
        ldone_out = 1'b0;
        {lctx_out, lack_out, lfail_out, lerr_out, lspd_out} = 16'hffff;
        forever begin
            @(posedge clk_in);
            if (xfer_go_in === 1'b1) begin
                repeat (dly_in) @(posedge clk_in);
                ldone_out <= 1'b1;
                {lctx_out, lack_out, lfail_out, lerr_out} <= {xfer_ctx_in, ack_in, fail_in, ~ack_in};
                lspd_out <= spd_in;
                @(posedge clk_in);
                ldone_out <= 1'b0;
                {lctx_out, lack_out, lfail_out, lspd_out} <= ~{xfer_ctx_in, ack_in, fail_in, spd_in};
            end
        end
    end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the async DMA context control top.
// Assumes the far side model and the bound port checker.
`timescale 1ns/1ps
module testbench;
    reg         clk_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg         soft_reset_in = 1'b0;
    reg  [11:0] addr_in = 12'h000;
    reg  [31:0] wdata_in = 32'h0;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg  [7:0]  dly = 8'h08;
    reg         fatal = 1'b0;
    reg  [31:0] nptr = 32'h4560_0001;
    reg  [4:0]  ack = 5'h11;
    reg         fail = 1'b0;
    reg  [2:0]  packet_speed = 3'h0;
    wire [31:0] rdata_out, fetch_addr_out, fetch_next_ptr_in;
    wire [1:0]  fetch_ctx_out, xfer_ctx_out, link_ctx_in;
    wire [3:0]  fetch_count_out;
    wire [4:0]  link_ack_in, link_err_in;
    wire [2:0]  link_speed_in;
    wire        fetch_req_out, fetch_done_in, fetch_fatal_in, xfer_go_out;
    wire        link_done_in, link_fail_in, irq_out;
    int         num_errors = 0;
    int         checks = 0;
    logic [31:0] v;

    always #5 clk_in = ~clk_in;

    adcc_top u_dut (.clk_in, .rst_b_in, .soft_reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .fetch_req_out, .fetch_ctx_out, .fetch_addr_out, .fetch_count_out,
        .fetch_done_in, .fetch_fatal_in, .fetch_next_ptr_in, .xfer_go_out, .xfer_ctx_out,
        .link_done_in, .link_ctx_in, .link_ack_in, .link_fail_in, .link_err_in,
        .link_speed_in, .irq_out);

    adcc_far_model u_far (.clk_in, .fetch_req_in(fetch_req_out), .xfer_go_in(xfer_go_out),
        .xfer_ctx_in(xfer_ctx_out), .dly_in(dly), .fatal_in(fatal), .nptr_in(nptr),
        .ack_in(ack), .fail_in(fail), .spd_in(packet_speed), .fdone_out(fetch_done_in),
        .ffatal_out(fetch_fatal_in), .fnext_out(fetch_next_ptr_in), .ldone_out(link_done_in),
        .lctx_out(link_ctx_in), .lack_out(link_ack_in), .lfail_out(link_fail_in),
        .lerr_out(link_err_in), .lspd_out(link_speed_in));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Register port cycles, one strobe cycle each
    task automatic wr(input [11:0] a, input [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rchk(input [11:0] a, input [31:0] msk, input [31:0] e, input string m);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 cmp(rdata_out & msk, e, m);
    endtask

    // Bounded wait: 0 fetch request, 1 link completion, 2 fetch answer
    task automatic wait_ev(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (!(sel == 0 ? fetch_req_out === 1'b1 : sel == 1 ? link_done_in === 1'b1
            : fetch_done_in === 1'b1) && n < 300);
        cmp({31'h0, n < 300}, 32'h1, "event wait");
    endtask

    task automatic t_regs;
        rchk(12'h1c0, 32'hffff_ffff, 32'h0, "ctl reset");
        rchk(12'h1cc, 32'hffff_ffff, 32'h0, "ptr reset");
        wr(12'h1a0, 32'hffff_ffff);
        rchk(12'h1a4, 32'hffff_ffff, 32'h0000_9000, "set ones");
        wr(12'h1a4, 32'hffff_ffff);
        rchk(12'h1a0, 32'hffff_ffff, 32'h0000_1000, "clr ones");
        wr(12'h1a0, 32'h0000_8000);
        @(posedge clk_in);
        soft_reset_in <= 1'b1;
        @(posedge clk_in);
        soft_reset_in <= 1'b0;
        rchk(12'h1a0, 32'hffff_ffff, 32'h0, "soft reset");
        wr(12'h000, 32'hffff_ffff);
        rchk(12'h000, 32'hffff_ffff, 32'h0, "unmapped");
        $display("t_regs done");
    endtask

    // Receive context walks three blocks, then suspends and is woken
    task automatic t_flow;
        logic [31:0] e;
        wr(12'h1cc, 32'h1230_0002);
        wr(12'h1c0, 32'h0000_9000);
        wait_ev(0);
        cmp(fetch_addr_out, 32'h1230_0000, "fetch addr");
        cmp({26'h0, fetch_ctx_out, fetch_count_out}, 32'h22, "ctx count");
        rchk(12'h1c4, 32'h0000_9c00, 32'h0000_8400, "wake off");
        for (int i = 0; i < 3; i++) begin
            wait_ev(1);
            e = {16'h0, 5'h10, i != 2, 2'h0, i[2:0], i == 2 ? ~ack : ack};
            packet_speed <= 3'(i + 1);
            ack <= ack + 5'h01;
            fail <= (i == 1);
            if (i == 1)
                nptr <= 32'h0;
            rchk(12'h1c0, 32'h0000_ffff, e, "completion");
        end
        rchk(12'h1cc, 32'hffff_ffff, 32'h4560_0001, "ptr advance");
        wr(12'h1c0, 32'h0000_1000);
        wait_ev(0);
        cmp(fetch_addr_out, 32'h4560_0000, "wake refetch");
        wait_ev(1);
        wr(12'h1c4, 32'h0000_8000);
        rchk(12'h1c0, 32'h0000_9c00, 32'h0, "stopped");
        fail <= 1'b0;
        $display("t_flow done");
    endtask

    // Fatal fetch on context 0, interrupt masked, raised and cleared
    task automatic t_fatal;
        fatal <= 1'b1;
        wr(12'h19c, 32'h0000_0a01);
        wr(12'h1f4, 32'h0);
        rchk(12'h1f0, 32'h0000_00ff, 32'h0000_0004, "flush");
        wr(12'h180, 32'h0000_8000);
        wait_ev(2);
        rchk(12'h184, 32'h0000_ffff, 32'h0000_8810, "dead");
        cmp({31'h0, irq_out}, 32'h0, "irq masked");
        wr(12'h1f4, 32'h0000_0010);
        #1 cmp({31'h0, irq_out}, 32'h1, "irq raised");
        rchk(12'h1f0, 32'h0000_00ff, 32'h0000_0010, "status");
        cmp({31'h0, irq_out}, 32'h0, "irq cleared");
        wr(12'h184, 32'h0000_8000);
        rchk(12'h180, 32'h0000_8c00, 32'h0, "dead cleared");
        fatal <= 1'b0;
        $display("t_fatal done");
    endtask

    task automatic close_out;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this bound is generous
    initial begin
        #100000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out;
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs;
        t_flow;
        t_fatal;
        close_out;
    end
endmodule
